// *** verilog/simu_pkg.sv ***
// ---------------------------------------------------------------
// Sense indicator mask unit: shared constants and types
// ---------------------------------------------------------------
package simu_pkg;

    // ---------------------------------------------------------------
    // Word layout
    // ---------------------------------------------------------------
    localparam int unsigned SIMU_WORD_W   = 36;            // Indicator word width
    localparam int unsigned SIMU_HALF_W   = 18;            // Half word / immediate width
    localparam int unsigned SIMU_LEFT_LO  = 0;             // First left-half position
    localparam int unsigned SIMU_RIGHT_LO = 18;            // First right-half position

    // Indicator value after reset
    localparam logic [0:SIMU_WORD_W-1] SIMU_SI_RESET = 36'h000000000;

    // ---------------------------------------------------------------
    // Instruction lengths in processor cycles
    // ---------------------------------------------------------------
    localparam logic [2:0] SIMU_CYC_CLEAR_HALF  = 3'h1;    // Clear half, immediate
    localparam logic [2:0] SIMU_CYC_TOGGLE_AC   = 3'h1;    // Toggle from arith reg
    localparam logic [2:0] SIMU_CYC_TOGGLE_ST   = 3'h2;    // Toggle from storage
    localparam logic [2:0] SIMU_CYC_TOGGLE_HALF = 3'h1;    // Toggle half, immediate
    localparam logic [2:0] SIMU_CYC_TRANSFER    = 3'h2;    // Transfer on indicators
    localparam logic [2:0] SIMU_CYC_SKIP_ST     = 3'h4;    // Skip, storage mask
    localparam logic [2:0] SIMU_CYC_SKIP_HALF   = 3'h3;    // Skip, immediate mask

    // ---------------------------------------------------------------
    // Operation codes presented by the sequencer
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        SIMU_OP_NONE                   = 4'h0,
        SIMU_OP_CLEAR_LEFT_HALF_IMM    = 4'h1,
        SIMU_OP_CLEAR_RIGHT_HALF_IMM   = 4'h2,
        SIMU_OP_TOGGLE_FROM_ARITH      = 4'h3,
        SIMU_OP_TOGGLE_FROM_STORAGE    = 4'h4,
        SIMU_OP_TOGGLE_LEFT_HALF_IMM   = 4'h5,
        SIMU_OP_TOGGLE_RIGHT_HALF_IMM  = 4'h6,
        SIMU_OP_TRANSFER_WHEN_ALL_ON   = 4'h7,
        SIMU_OP_TRANSFER_WHEN_ALL_OFF  = 4'h8,
        SIMU_OP_SKIP_ON_STORAGE_MASK   = 4'h9,
        SIMU_OP_SKIP_OFF_STORAGE_MASK  = 4'hA,
        SIMU_OP_SKIP_ON_LEFT_HALF      = 4'hB,
        SIMU_OP_SKIP_ON_RIGHT_HALF     = 4'hC,
        SIMU_OP_SKIP_OFF_LEFT_HALF     = 4'hD,
        SIMU_OP_SKIP_OFF_RIGHT_HALF    = 4'hE
    } simu_op_t;

    // Execution state
    typedef enum logic [0:0] {
        SIMU_ST_IDLE = 1'h0,
        SIMU_ST_BUSY = 1'h1
    } simu_state_t;

endpackage : simu_pkg

// *** verilog/simu_mask_test.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Mask test: are all selected indicators on, or all off
// ---------------------------------------------------------------
module simu_mask_test #(
    parameter int unsigned WIDTH = 36                  // Positions examined
) (
    input  wire logic [0:WIDTH-1] indicators,          // Current indicator state
    input  wire logic [0:WIDTH-1] mask,                // Ones select positions
    output logic                  all_on,              // Every selected position is 1
    output logic                  all_off              // Every selected position is 0
);

    // Unselected positions are ignored; an empty mask passes both tests
    always_comb begin
        all_on  = ((indicators & mask) == mask);
        all_off = ((indicators & mask) == '0);
    end

endmodule : simu_mask_test

// *** verilog/simu_core.sv ***
`timescale 1ns/10ps
// What this block does
// - Holds 36 settable, testable sense indicators
// - Only mask-one positions are touched or tested
// - Left-half immediate clear, one cycle
// - Right-half immediate clear, one cycle
// - Arith register toggles indicators, one cycle
// - A one flips a position, zero leaves
// - Storage word toggles indicators, two cycles
// - Left-half immediate toggle, one cycle
// - Right-half immediate toggle, one cycle
// - Transfer when all selected on, two cycles
// - Transfer when all selected off, two cycles
// - Skip if storage-selected all on, four cycles
// - Skip if storage-selected all off, four cycles
// - Skip if left-half selected all on
// - Skip if right-half selected all on
// - Skip if left-half selected all off
// - Skip if right-half selected all off
module simu_core
    import simu_pkg::*;
#(
    parameter int unsigned WORD_W = simu_pkg::SIMU_WORD_W,  // Indicator word width
    parameter int unsigned HALF_W = simu_pkg::SIMU_HALF_W   // Immediate field width
) (
    input  wire logic                       clk,            // 50 MHz processor clock
    input  wire logic                       nrst,           // Async reset, active low
    input  wire logic                       op_start,       // Sequencer issues an operation
    input  wire simu_pkg::simu_op_t         op_code,        // Operation to execute
    input  wire logic [0:WORD_W-1]          main_arith_reg, // Arith register P,1-35
    input  wire logic [0:WORD_W-1]          storage_word,   // Operand word S,1-35
    input  wire logic [0:HALF_W-1]          imm_mask,       // Instruction bits 18-35
    input  wire logic                       trap_mode,      // Transfer trap mode active
    output logic                            op_ready,       // Unit can take an operation
    output logic                            op_done,        // Operation finished, one cycle
    output logic                            transfer_taken, // Go to operand location
    output logic                            trap_taken,     // Taken transfer trapped instead
    output logic                            skip_next,      // Skip the next instruction
    output logic [0:WORD_W-1]               sense_ind       // Indicator contents
);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    if (WORD_W != 2 * HALF_W) begin : g_bad_width
        $error("simu_core: word width must be twice the half width");
    end
    if (HALF_W == 0) begin : g_bad_half
        $error("simu_core: half width must be nonzero");
    end

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Place an immediate mask over the left or right half of the word
    function automatic logic [0:WORD_W-1] half_mask(
        input logic [0:HALF_W-1] imm,
        input logic              right
    );
        logic [0:WORD_W-1] m;
        m = '0;
        if (right) begin
            m[HALF_W +: HALF_W] = imm;                      // Positions 18-35
        end else begin
            m[0 +: HALF_W] = imm;                           // Positions 0-17
        end
        return m;
    endfunction : half_mask

    // Number of processor cycles an operation occupies
    function automatic logic [2:0] op_cycles(input simu_op_t op);
        logic [2:0] n;
        n = 3'h1;
        case (op)
            SIMU_OP_CLEAR_LEFT_HALF_IMM,
            SIMU_OP_CLEAR_RIGHT_HALF_IMM:  n = SIMU_CYC_CLEAR_HALF;
            SIMU_OP_TOGGLE_FROM_ARITH:     n = SIMU_CYC_TOGGLE_AC;
            SIMU_OP_TOGGLE_FROM_STORAGE:   n = SIMU_CYC_TOGGLE_ST;
            SIMU_OP_TOGGLE_LEFT_HALF_IMM,
            SIMU_OP_TOGGLE_RIGHT_HALF_IMM: n = SIMU_CYC_TOGGLE_HALF;
            SIMU_OP_TRANSFER_WHEN_ALL_ON,
            SIMU_OP_TRANSFER_WHEN_ALL_OFF: n = SIMU_CYC_TRANSFER;
            SIMU_OP_SKIP_ON_STORAGE_MASK,
            SIMU_OP_SKIP_OFF_STORAGE_MASK: n = SIMU_CYC_SKIP_ST;
            SIMU_OP_SKIP_ON_LEFT_HALF,
            SIMU_OP_SKIP_ON_RIGHT_HALF,
            SIMU_OP_SKIP_OFF_LEFT_HALF,
            SIMU_OP_SKIP_OFF_RIGHT_HALF:   n = SIMU_CYC_SKIP_HALF;
            default:                       n = 3'h1;
        endcase
        return n;
    endfunction : op_cycles

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    simu_state_t       state_reg,    state_next;
    simu_op_t          op_reg,       op_next;
    logic [2:0]        cnt_reg,      cnt_next;
    logic [0:WORD_W-1] mask_reg,     mask_next;
    logic [0:WORD_W-1] si_reg,       si_next;
    logic              done_reg,     done_next;
    logic              xfer_reg,     xfer_next;
    logic              trap_reg,     trap_next;
    logic              skip_reg,     skip_next_v;
    logic              trap_mode_reg, trap_mode_next;

    // Mask built at issue time from the source the operation names
    logic [0:WORD_W-1] issue_mask;
    logic              test_on;
    logic              test_off;
    logic              accept;

    // ---------------------------------------------------------------
    // Mask selection at issue
    // ---------------------------------------------------------------

    // Pick the mask source for the operation being issued
    always_comb begin
        issue_mask = '0;
        case (op_code)
            SIMU_OP_CLEAR_LEFT_HALF_IMM,
            SIMU_OP_TOGGLE_LEFT_HALF_IMM,
            SIMU_OP_SKIP_ON_LEFT_HALF,
            SIMU_OP_SKIP_OFF_LEFT_HALF:
                issue_mask = half_mask(imm_mask, 1'b0);
            SIMU_OP_CLEAR_RIGHT_HALF_IMM,
            SIMU_OP_TOGGLE_RIGHT_HALF_IMM,
            SIMU_OP_SKIP_ON_RIGHT_HALF,
            SIMU_OP_SKIP_OFF_RIGHT_HALF:
                issue_mask = half_mask(imm_mask, 1'b1);
            SIMU_OP_TOGGLE_FROM_ARITH,
            SIMU_OP_TRANSFER_WHEN_ALL_ON,
            SIMU_OP_TRANSFER_WHEN_ALL_OFF:
                issue_mask = main_arith_reg;
            SIMU_OP_TOGGLE_FROM_STORAGE,
            SIMU_OP_SKIP_ON_STORAGE_MASK,
            SIMU_OP_SKIP_OFF_STORAGE_MASK:
                issue_mask = storage_word;
            default:
                issue_mask = '0;
        endcase
    end

    // ---------------------------------------------------------------
    // Mask test on the latched mask
    // ---------------------------------------------------------------

    // Test of the current indicators against the held mask
    simu_mask_test #(
        .WIDTH      (WORD_W)
    ) u_test (
        .indicators (si_reg),
        .mask       (mask_reg),
        .all_on     (test_on),
        .all_off    (test_off)
    );

    // ---------------------------------------------------------------
    // Sequencing and indicator update
    // ---------------------------------------------------------------

    // Handshake: take a new operation only while idle
    assign accept   = op_start && (state_reg == SIMU_ST_IDLE) && (op_code != SIMU_OP_NONE);
    assign op_ready = (state_reg == SIMU_ST_IDLE);

    // Next-state logic for the whole unit
    always_comb begin
        state_next     = state_reg;
        op_next        = op_reg;
        cnt_next       = cnt_reg;
        mask_next      = mask_reg;
        si_next        = si_reg;
        trap_mode_next = trap_mode_reg;
        done_next      = 1'b0;
        xfer_next      = 1'b0;
        trap_next      = 1'b0;
        skip_next_v    = 1'b0;
        case (state_reg)
            SIMU_ST_IDLE: begin
                if (accept) begin
                    state_next     = SIMU_ST_BUSY;
                    op_next        = op_code;
                    mask_next      = issue_mask;
                    trap_mode_next = trap_mode;
                    cnt_next       = 3'(op_cycles(op_code) - 3'h1);
                end
            end
            SIMU_ST_BUSY: begin
                if (cnt_reg != 3'h0) begin
                    cnt_next = 3'(cnt_reg - 3'h1);          // Hold for the cycle count
                end else begin
                    state_next = SIMU_ST_IDLE;
                    done_next  = 1'b1;
                    case (op_reg)
                        SIMU_OP_CLEAR_LEFT_HALF_IMM,
                        SIMU_OP_CLEAR_RIGHT_HALF_IMM:
                            si_next = si_reg & ~mask_reg;
                        SIMU_OP_TOGGLE_FROM_ARITH,
                        SIMU_OP_TOGGLE_FROM_STORAGE,
                        SIMU_OP_TOGGLE_LEFT_HALF_IMM,
                        SIMU_OP_TOGGLE_RIGHT_HALF_IMM:
                            si_next = si_reg ^ mask_reg;
                        SIMU_OP_TRANSFER_WHEN_ALL_ON: begin
                            xfer_next = test_on && !trap_mode_reg;
                            trap_next = test_on && trap_mode_reg;
                        end
                        SIMU_OP_TRANSFER_WHEN_ALL_OFF: begin
                            xfer_next = test_off && !trap_mode_reg;
                            trap_next = test_off && trap_mode_reg;
                        end
                        SIMU_OP_SKIP_ON_STORAGE_MASK:
                            skip_next_v = test_on;
                        SIMU_OP_SKIP_OFF_STORAGE_MASK:
                            skip_next_v = test_off;
                        SIMU_OP_SKIP_ON_LEFT_HALF:
                            skip_next_v = test_on;
                        SIMU_OP_SKIP_ON_RIGHT_HALF:
                            skip_next_v = test_on;
                        SIMU_OP_SKIP_OFF_LEFT_HALF:
                            skip_next_v = test_off;
                        SIMU_OP_SKIP_OFF_RIGHT_HALF:
                            skip_next_v = test_off;
                        default: begin
                            si_next = si_reg;
                        end
                    endcase
                end
            end
            default: begin
                state_next = SIMU_ST_IDLE;
            end
        endcase
    end

    // Registers of the unit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= SIMU_ST_IDLE;
            op_reg        <= SIMU_OP_NONE;
            cnt_reg       <= 3'h0;
            mask_reg      <= '0;
            si_reg        <= SIMU_SI_RESET;
            trap_mode_reg <= 1'b0;
            done_reg      <= 1'b0;
            xfer_reg      <= 1'b0;
            trap_reg      <= 1'b0;
            skip_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            op_reg        <= op_next;
            cnt_reg       <= cnt_next;
            mask_reg      <= mask_next;
            si_reg        <= si_next;
            trap_mode_reg <= trap_mode_next;
            done_reg      <= done_next;
            xfer_reg      <= xfer_next;
            trap_reg      <= trap_next;
            skip_reg      <= skip_next_v;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------

    // Results come straight from flip-flops
    assign op_done        = done_reg;
    assign transfer_taken = xfer_reg;
    assign trap_taken     = trap_reg;
    assign skip_next      = skip_reg;
    assign sense_ind      = si_reg;

endmodule : simu_core

// *** bench/simu_core_checker.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Port checker for the mask unit
// ---------------------------------------------------------------
module simu_core_checker
    import simu_pkg::*;
#(
    parameter int unsigned WORD_W = 36,            // Indicator width
    parameter int unsigned HALF_W = 18             // Immediate width
) (
    input wire logic               clk,            // Clock
    input wire logic               nrst,           // Reset, active low
    input wire logic               op_start,       // Request
    input wire simu_pkg::simu_op_t op_code,        // Operation
    input wire logic [0:WORD_W-1]  main_arith_reg, // Arith mask
    input wire logic [0:WORD_W-1]  storage_word,   // Storage mask
    input wire logic [0:HALF_W-1]  imm_mask,       // Immediate mask
    input wire logic               trap_mode,      // Trap mode
    input wire logic               op_ready,       // Idle
    input wire logic               op_done,        // Finished
    input wire logic               transfer_taken, // Transfer
    input wire logic               trap_taken,     // Trap
    input wire logic               skip_next,      // Skip
    input wire logic [0:WORD_W-1]  sense_ind       // Indicators
);
    // Accepted request and masked indicators
    wire              acc   = op_start && op_ready && (op_code != SIMU_OP_NONE);
    wire [0:WORD_W-1] si_ac = sense_ind & main_arith_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_one_cycle_ops: assert property (acc && op_code inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6}
        |=> !op_done ##1 op_done) else $error("one-cycle op late");
    a_two_cycle_ops: assert property (acc && op_code inside {4'h4, 4'h7, 4'h8}
        |=> !op_done[*2] ##1 op_done) else $error("two-cycle op timing");
    a_skip_store_len: assert property (acc && op_code inside {4'h9, 4'hA}
        |=> !op_done[*4] ##1 op_done) else $error("storage skip timing");
    a_skip_half_len: assert property (acc && op_code inside {4'hB, 4'hC, 4'hD, 4'hE}
        |=> !op_done[*3] ##1 op_done) else $error("half skip timing");
    a_toggle_arith_val: assert property (acc && op_code == SIMU_OP_TOGGLE_FROM_ARITH
        |=> ##1 sense_ind == ($past(sense_ind, 2) ^ $past(main_arith_reg, 2)))
        else $error("arith toggle value");
    a_clear_right_val: assert property (acc && op_code == SIMU_OP_CLEAR_RIGHT_HALF_IMM
        |=> ##1 sense_ind[HALF_W:WORD_W-1]
        == ($past(sense_ind[HALF_W:WORD_W-1], 2) & ~$past(imm_mask, 2))
        && sense_ind[0:HALF_W-1] == $past(sense_ind[0:HALF_W-1], 2))
        else $error("right clear value");
    a_si_only_done: assert property (!$stable(sense_ind) |-> op_done)
        else $error("indicators moved outside op end");
    a_xfer_on_hit: assert property (acc && op_code == SIMU_OP_TRANSFER_WHEN_ALL_ON && !trap_mode
        && si_ac == main_arith_reg |-> ##3 transfer_taken)
        else $error("transfer not taken");
    a_xfer_off_miss: assert property (acc && op_code == SIMU_OP_TRANSFER_WHEN_ALL_OFF
        && si_ac != '0 |-> ##3 !(transfer_taken || trap_taken))
        else $error("transfer taken on miss");
    a_flags_with_done: assert property ((transfer_taken || trap_taken || skip_next) |-> op_done
        && !(transfer_taken && trap_taken)) else $error("stray flag");

    // Main scenarios reached
    c_trap: cover property (acc && op_code == SIMU_OP_TRANSFER_WHEN_ALL_ON ##3 trap_taken);
    c_skip: cover property (skip_next);
    c_refused: cover property (op_start && !op_ready);
endmodule : simu_core_checker

bind simu_core simu_core_checker #(.WORD_W(WORD_W), .HALF_W(HALF_W)) u_chk (
    .clk(clk), .nrst(nrst), .op_start(op_start), .op_code(op_code),
    .main_arith_reg(main_arith_reg), .storage_word(storage_word), .imm_mask(imm_mask),
    .trap_mode(trap_mode), .op_ready(op_ready), .op_done(op_done),
    .transfer_taken(transfer_taken), .trap_taken(trap_taken), .skip_next(skip_next),
    .sense_ind(sense_ind));

// *** bench/simu_seq_model.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Sequencer model: follows the unit's decisions
// ---------------------------------------------------------------
module simu_seq_model #(
    parameter logic [14:0] XFER_TARGET = 15'h0100, // Operand location
    parameter logic [14:0] TRAP_TARGET = 15'h0001  // Trap location
) (
    input wire logic  clk,            // Clock
    input wire logic  nrst,           // Reset, active low
    input wire logic  op_done,        // Op finished
    input wire logic  transfer_taken, // Go to operand
    input wire logic  trap_taken,     // Trap instead
    input wire logic  skip_next,      // Skip one
    output logic [14:0] pc_reg        // Instruction counter
);
    logic [14:0] pc_next;
    // Next location from the decision flags
    always_comb begin
        pc_next = pc_reg;
        if (op_done) begin
            if (transfer_taken) pc_next = XFER_TARGET;
            else if (trap_taken) pc_next = TRAP_TARGET;
            else pc_next = pc_reg + (skip_next ? 15'h0002 : 15'h0001);
        end
    end
    // Counter register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) pc_reg <= 15'h0000;
        else pc_reg <= pc_next;
    end
endmodule : simu_seq_model

// *** bench/simu_core_bench.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Self-checking bench for the mask unit
// ---------------------------------------------------------------
module simu_core_bench;
    import simu_pkg::*;
    typedef struct {logic [0:35] si; logic x; logic t; logic s; int lat; int acc;} simu_note_t;
    logic        clk = 1'b0;
    logic        nrst, op_start, trap_mode, op_ready, op_done, xfer, trap, skip;
    simu_op_t    op_code;
    logic [0:35] main_arith_reg, storage_word, sense_ind, exp_si, msk;
    logic [0:17] imm_mask;
    logic [14:0] pc, exp_pc;
    logic [31:0] rng = 32'h0000A4F8;
    simu_note_t  notes[$];
    simu_note_t  mn;
    int          mismatches = 0, n_checks = 0, cyc = 0;

    simu_core #(.WORD_W(36), .HALF_W(18)) dut_u (.clk(clk), .nrst(nrst), .op_start(op_start),
        .op_code(op_code), .main_arith_reg(main_arith_reg), .storage_word(storage_word),
        .imm_mask(imm_mask), .trap_mode(trap_mode), .op_ready(op_ready), .op_done(op_done),
        .transfer_taken(xfer), .trap_taken(trap), .skip_next(skip), .sense_ind(sense_ind));
    simu_seq_model #(.XFER_TARGET(15'h0100), .TRAP_TARGET(15'h0001)) seq_u (.clk(clk),
        .nrst(nrst), .op_done(op_done), .transfer_taken(xfer), .trap_taken(trap),
        .skip_next(skip), .pc_reg(pc));

    // Clock, cycle count and hang limit
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            final_report();
        end
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Issue one op, note its expected result
    task automatic do_op(input simu_op_t op, input logic [0:35] m, input logic tm);
        simu_note_t  n;
        logic        rt, on, off;
        logic [0:35] e;
        rt = op inside {4'h2, 4'h6, 4'hC, 4'hE};
        e = !(op inside {4'h1, 4'h2, 4'h5, 4'h6, 4'hB, 4'hC, 4'hD, 4'hE}) ? m :
            rt ? {18'h00000, m[18:35]} : {m[0:17], 18'h00000};
        on = (exp_si & e) == e;
        off = (exp_si & e) == 36'h000000000;
        n = '{exp_si, 1'b0, 1'b0, 1'b0, 3, 0};
        case (op)
            4'h1, 4'h2: n.si = exp_si & ~e;
            4'h3, 4'h4, 4'h5, 4'h6: n.si = exp_si ^ e;
            4'h7: {n.x, n.t} = {on & !tm, on & tm};
            4'h8: {n.x, n.t} = {off & !tm, off & tm};
            4'h9, 4'hB, 4'hC: n.s = on;
            default: n.s = off;
        endcase
        n.lat = op inside {4'h4, 4'h7, 4'h8} ? 2 : op inside {4'h9, 4'hA} ? 4 :
            op inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6} ? 1 : 3;
        exp_pc = n.x ? 15'h0100 : n.t ? 15'h0001 : exp_pc + (n.s ? 15'h0002 : 15'h0001);
        @(negedge clk);
        while (op_ready !== 1'b1) begin
            op_start = 1'b1;
            op_code = SIMU_OP_TOGGLE_FROM_ARITH;
            main_arith_reg = ~m;
            @(negedge clk);
        end
        op_start = 1'b1;
        op_code = op;
        main_arith_reg = m;
        storage_word = m;
        imm_mask = rt ? m[18:35] : m[0:17];
        trap_mode = tm;
        @(posedge clk);
        n.acc = cyc;
        notes.push_back(n);
        exp_si = n.si;
    endtask : do_op

    // Result watcher: oldest note against each finished op
    always @(negedge clk) begin
        if (nrst === 1'b1 && op_done === 1'b1) begin
            if (notes.size() == 0) check("unexpected op_done", 36'h1, 36'h0);
            else begin
                mn = notes.pop_front();
                check("sense_ind", sense_ind, mn.si);
                check("flags", {33'h0, xfer, trap, skip}, {33'h0, mn.x, mn.t, mn.s});
                check("latency", 36'(cyc - mn.acc), 36'(mn.lat + 1));
                check("op_ready", {35'h0, op_ready}, 36'h1);
            end
        end
    end

    // Main sequence
    initial begin
        {nrst, op_start, trap_mode} = 3'h0;
        op_code = SIMU_OP_NONE;
        {main_arith_reg, storage_word, imm_mask, exp_si, exp_pc} = '0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        for (int t = 0; t < 2; t++) begin
            for (int r = 0; r < 8; r++) begin
                for (int k = 1; k < 15; k++) begin
                    msk = {xs(), xs()};
                    case (t ? xs() % 4 : r % 4)
                        1: msk = '0;
                        2: msk = exp_si;
                        3: msk = ~exp_si;
                        default: ;
                    endcase
                    do_op(simu_op_t'(k), msk, rng[3]);
                end
            end
            @(negedge clk);
            op_start = 1'b0;
            for (int i = 0; i < 10 && notes.size() != 0; i++) @(negedge clk);
            @(negedge clk);
            check("pc", {21'h0, pc}, {21'h0, exp_pc});
            $display("test %0d done", t);
        end
        final_report();
    end
endmodule : simu_core_bench
